// ===== logic/lane_shifter.sv
// one serial output lane: parallel load, shift msb first
`timescale 1ns/100ps
`default_nettype none
module lane_shifter #(
	parameter int BITS = 64
) (
	input wire logic clk_sys,
	input wire logic rstn,
	lane_if.lane     port
);
	logic [BITS-1:0] word_reg;
	logic [BITS-1:0] word_next;

	if (BITS < 2) begin : g_bad_bits
		$error("lane_shifter needs at least two bits");
	end

	// load wins over shift; shift pulls in the chained bit
	always_comb begin
		word_next = word_reg;
		if (port.loadEn) begin
			word_next = port.loadWord;
		end else if (port.shiftEn) begin
			word_next = {word_reg[BITS-2:0], port.serialIn}; // [R7]
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			word_reg <= '0;
		end else begin
			word_reg <= word_next;
		end
	end

	assign port.serialOut = word_reg[BITS-1];

	chk_lane_advance: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
		port.shiftEn && !port.loadEn |=> port.serialOut == $past(word_reg[BITS-2]))
		else $error("lane did not advance by one bit");
endmodule
`default_nettype wire

// ===== logic/readout_core.sv
// integrator readout core: apb registers, measurement timing, serial readout
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module readout_core
	import readout_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  masterClk,
	input  wire logic                  integrateSideSelect,
	input  wire logic                  readoutShiftClock,
	input  wire logic                  daisyIn,
	input  wire logic                  cfgSerialIn,
	input  wire logic [CHAIN_BITS-1:0] channelResults,
	output logic                       resultReadyN,
	output logic      [LANE_COUNT-1:0] serialOutLanes,
	output logic                       integratingSideA,
	output logic      [1:0]            rangeSelect,
	output logic                       refBufferBypass,
	output logic                       shortIntegrationSelect,
	output logic                       irq
);
	// ************************************************
	// pin synchronisers and edge detection
	// ************************************************
	logic [PIN_COUNT-1:0] pinMeta_reg;
	logic [PIN_COUNT-1:0] pinSync_reg;
	logic [PIN_COUNT-1:0] pinPrev_reg;
	logic [PIN_COUNT-1:0] pinRaw;
	logic                 mclkRise;
	logic                 mclkFall;
	logic                 sideToggle;
	logic                 dclkRise;
	logic                 dclkFall;

	assign pinRaw = {cfgSerialIn, daisyIn, readoutShiftClock, integrateSideSelect, masterClk};

	// two stages, then a history stage for edges
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
			pinPrev_reg <= '0;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			pinPrev_reg <= pinSync_reg;
		end
	end

	// edges seen on the synchronised levels
	assign mclkRise   = pinSync_reg[PIN_MCLK] & ~pinPrev_reg[PIN_MCLK];
	assign mclkFall   = ~pinSync_reg[PIN_MCLK] & pinPrev_reg[PIN_MCLK];
	assign sideToggle = pinSync_reg[PIN_SIDE] ^ pinPrev_reg[PIN_SIDE];
	assign dclkRise   = pinSync_reg[PIN_READOUT_SHIFT_CLOCK] & ~pinPrev_reg[PIN_READOUT_SHIFT_CLOCK];
	assign dclkFall   = ~pinSync_reg[PIN_READOUT_SHIFT_CLOCK] & pinPrev_reg[PIN_READOUT_SHIFT_CLOCK];
	assign integratingSideA = pinSync_reg[PIN_SIDE]; // [R2]

	// ************************************************
	// state declarations
	// ************************************************
	logic [CFG_BITS-1:0] cfg_reg, cfg_next;
	logic                armed_reg, armed_next;
	logic [CFG_BITS-1:0] cfgShift_reg, cfgShift_next;
	logic [3:0]          cfgCnt_reg, cfgCnt_next;
	logic                readbackPend_reg, readbackPend_next;
	meas_state_t         measState_reg, measState_next;
	logic [9:0]          measCount_reg, measCount_next;
	logic                resultReadyN_reg, resultReadyN_next;
	logic                daisyBit_reg, daisyBit_next;
	logic [IRQ_BITS-1:0] irqStat_reg, irqStat_next;
	logic [IRQ_BITS-1:0] irqMask_reg, irqMask_next;
	logic                irq_reg, irq_next;
	logic                pready_reg, pready_next;
	logic                pslverr_reg, pslverr_next;
	logic [31:0]         prdata_reg, prdata_next;
	logic                apbAccess;
	logic                wrCommit;
	logic                mapped;
	logic                cfgDone;
	logic                measDone;
	logic                readbackLoad;
	logic                loadNow;
	logic                shiftNow;
	logic                fourLane;
	logic [9:0]          measTarget;
	logic [IRQ_BITS-1:0] irqEvents;
	logic [IRQ_BITS-1:0] irqClear;

	// ************************************************
	// apb decode
	// ************************************************
	assign apbAccess = psel & penable & ~pready_reg;
	assign wrCommit  = psel & penable & pready_reg & pwrite;
	assign mapped    = (paddr == OFS_CONFIG) | (paddr == OFS_CTRL) | (paddr == OFS_STATUS)
		| (paddr == OFS_IRQ_STAT) | (paddr == OFS_IRQ_MASK);

	// ready one cycle into access, read data and error with it
	always_comb begin
		pready_next  = apbAccess;
		pslverr_next = apbAccess & ~mapped;
		prdata_next  = '0;
		if (apbAccess) begin
			case (paddr)
				OFS_CONFIG:   prdata_next[CFG_BITS-1:0] = cfg_reg;
				OFS_CTRL:     prdata_next[1:0] = {readbackPend_reg, armed_reg};
				OFS_STATUS:   prdata_next[3:0] = {armed_reg, resultReadyN_reg,
					measState_reg == MEAS_RUN, pinSync_reg[PIN_SIDE]};
				OFS_IRQ_STAT: prdata_next[IRQ_BITS-1:0] = irqStat_reg;
				OFS_IRQ_MASK: prdata_next[IRQ_BITS-1:0] = irqMask_reg;
				default:      prdata_next = '0;
			endcase
		end
	end

	// ************************************************
	// configuration: apb writes, serial capture, readback
	// ************************************************
	assign fourLane     = cfg_reg[CFG_FOUR_LANE_BIT];
	assign readbackLoad = readbackPend_reg & mclkFall & ~measDone; // [R10]

	always_comb begin
		cfg_next          = cfg_reg;
		armed_next        = armed_reg;
		cfgShift_next     = cfgShift_reg;
		cfgCnt_next       = cfgCnt_reg;
		readbackPend_next = readbackPend_reg;
		irqMask_next      = irqMask_reg;
		cfgDone           = 1'b0;
		if (readbackLoad) begin
			readbackPend_next = 1'b0;
		end
		// serial bits on master clock falling edges
		if (armed_reg && mclkFall) begin
			cfgShift_next = {cfgShift_reg[CFG_BITS-2:0], pinSync_reg[PIN_CFG]}; // [R9]
			cfgCnt_next   = cfgCnt_reg + 4'h1;
			if (cfgCnt_reg == CFG_LAST_BIT) begin
				cfg_next   = {cfgShift_reg[CFG_BITS-2:0], pinSync_reg[PIN_CFG]}; // [R9]
				armed_next = 1'b0;
				cfgDone    = 1'b1;
			end
		end
		// bus writes come after, so they take priority
		if (wrCommit && paddr == OFS_CONFIG) begin
			cfg_next = pwdata[CFG_BITS-1:0];
		end
		if (wrCommit && paddr == OFS_CTRL) begin
			if (pwdata[CTRL_ARM_BIT]) begin
				armed_next  = 1'b1;
				cfgCnt_next = '0;
			end
			if (pwdata[CTRL_READBACK_BIT]) begin
				readbackPend_next = 1'b1;
			end
		end
		if (wrCommit && paddr == OFS_IRQ_MASK) begin
			irqMask_next = pwdata[IRQ_BITS-1:0];
		end
	end

	// ************************************************
	// measurement timing and readout handshake
	// ************************************************
	assign measTarget = cfg_reg[CFG_SHORT_BIT] ? MEAS_CLKS_SHORT : MEAS_CLKS_NORMAL; // [R3]

	always_comb begin
		measState_next    = measState_reg;
		measCount_next    = measCount_reg;
		resultReadyN_next = resultReadyN_reg;
		daisyBit_next     = daisyBit_reg;
		measDone          = 1'b0;
		unique case (measState_reg)
			MEAS_IDLE: begin
				measCount_next = measCount_reg;
			end
			MEAS_RUN: begin
				if (mclkRise) begin
					measCount_next = measCount_reg + 10'h001;
					if (measCount_reg == measTarget - 10'h001) begin
						measDone       = 1'b1; // [R3]
						measState_next = MEAS_IDLE;
					end
				end
			end
		endcase
		// a side switch starts a fresh measurement
		if (sideToggle) begin
			measState_next = MEAS_RUN; // [R3]
			measCount_next = '0;
		end
		if (dclkRise) begin
			daisyBit_next = pinSync_reg[PIN_DAISY]; // [R8]
		end
		if (measDone || readbackLoad) begin
			resultReadyN_next = 1'b0; // [R4] [R10]
		end else if (dclkFall) begin
			resultReadyN_next = 1'b1; // [R6]
		end
	end

	// ************************************************
	// interrupt status, set wins over clear
	// ************************************************
	always_comb begin
		irqEvents                 = '0;
		irqEvents[IRQ_MEAS_DONE]  = measDone;
		irqEvents[IRQ_READ_START] = dclkFall & ~resultReadyN_reg;
		irqEvents[IRQ_CFG_DONE]   = cfgDone;
		irqEvents[IRQ_OVERRUN]    = measDone & ~resultReadyN_reg;
		irqClear                  = '0;
		if (wrCommit && paddr == OFS_IRQ_STAT) begin
			irqClear = pwdata[IRQ_BITS-1:0];
		end
		irqStat_next = (irqStat_reg & ~irqClear) | irqEvents;
		irq_next     = |(irqStat_next & irqMask_next);
	end

	// ************************************************
	// state registers
	// ************************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin // [R5]
			cfg_reg          <= CFG_RESET;
			armed_reg        <= 1'b0;
			cfgShift_reg     <= '0;
			cfgCnt_reg       <= '0;
			readbackPend_reg <= 1'b0;
			measState_reg    <= MEAS_IDLE;
			measCount_reg    <= '0;
			resultReadyN_reg <= 1'b1;
			daisyBit_reg     <= 1'b0;
			irqStat_reg      <= '0;
			irqMask_reg      <= '0;
			irq_reg          <= 1'b0;
			pready_reg       <= 1'b0;
			pslverr_reg      <= 1'b0;
			prdata_reg       <= '0;
		end else begin
			cfg_reg          <= cfg_next;
			armed_reg        <= armed_next;
			cfgShift_reg     <= cfgShift_next;
			cfgCnt_reg       <= cfgCnt_next;
			readbackPend_reg <= readbackPend_next;
			measState_reg    <= measState_next;
			measCount_reg    <= measCount_next;
			resultReadyN_reg <= resultReadyN_next;
			daisyBit_reg     <= daisyBit_next;
			irqStat_reg      <= irqStat_next;
			irqMask_reg      <= irqMask_next;
			irq_reg          <= irq_next;
			pready_reg       <= pready_next;
			pslverr_reg      <= pslverr_next;
			prdata_reg       <= prdata_next;
		end
	end

	// register-backed outputs
	assign prdata                 = prdata_reg;
	assign pready                 = pready_reg;
	assign pslverr                = pslverr_reg;
	assign resultReadyN           = resultReadyN_reg;
	assign irq                    = irq_reg;
	assign rangeSelect            = cfg_reg[CFG_RANGE_LSB +: 2]; // [R15]
	assign refBufferBypass        = cfg_reg[CFG_BYPASS_BIT]; // [R13]
	assign shortIntegrationSelect = cfg_reg[CFG_SHORT_BIT];

	// ************************************************
	// result packing and output lanes
	// ************************************************
	function automatic logic [CHAIN_BITS-1:0] packResults(input logic [CHAIN_BITS-1:0] res,
		input logic [1:0] resSel, input logic oneLanePerGroup);
		logic [CHAIN_BITS-1:0] packedV;
		int                    width;
		int                    base;
		packedV = '0;
		width   = (resSel == RES_12) ? RES_WIDTH_12 : (resSel == RES_14) ? RES_WIDTH_14 : WORD_BITS;
		for (int c = 0; c < CH_COUNT; c++) begin
			base = oneLanePerGroup ? (c / CH_PER_LANE) * LANE_BITS + (c % CH_PER_LANE) * width
				: c * width;
			for (int b = 0; b < WORD_BITS; b++) begin
				if (b < width) begin
					packedV[CHAIN_BITS-1-base-b] = res[CHAIN_BITS-1-c*WORD_BITS-b]; // [R12] [R14] [R17]
				end
			end
		end
		return packedV;
	endfunction

	logic [CHAIN_BITS-1:0] packedWords;
	always_comb packedWords = packResults(channelResults, cfg_reg[CFG_RES_LSB +: 2], fourLane);

	assign loadNow  = measDone | readbackLoad;
	assign shiftNow = dclkFall & ~loadNow; // [R7]

	lane_if #(.BITS(LANE_BITS)) lanes [LANE_COUNT] ();

	// each lane loads its slice, zeros on readback past lane 0; chain feeds from the next lane, or daisy at the tail; four-lane mode feeds zeros except at the tail
	for (genvar k = 0; k < LANE_COUNT; k++) begin : g_lane
		assign lanes[k].loadEn  = loadNow;
		assign lanes[k].shiftEn = shiftNow;
		if (k == 0) begin : g_first
			assign lanes[k].loadWord = readbackLoad ? {cfg_reg, {(LANE_BITS-CFG_BITS){1'b0}}} // [R11]
				: packedWords[CHAIN_BITS-1 -: LANE_BITS];
		end else begin : g_rest
			assign lanes[k].loadWord = readbackLoad ? '0 : packedWords[CHAIN_BITS-1-k*LANE_BITS -: LANE_BITS];
		end
		if (k == LANE_COUNT - 1) begin : g_tail
			assign lanes[k].serialIn = daisyBit_reg; // [R8]
		end else begin : g_link
			assign lanes[k].serialIn = fourLane ? 1'b0 : lanes[k+1].serialOut;
		end
		lane_shifter #(.BITS(LANE_BITS)) u_lane (
			.clk_sys (clk_sys),
			.rstn    (rstn),
			.port    (lanes[k])
		);
		assign serialOutLanes[k] = lanes[k].serialOut;
	end

	// ************************************************
	// assertions and covers
	// ************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	chk_side_follow: assert property ($past(rstn, 2) |-> integratingSideA == $past(integrateSideSelect, 2)) // [R2]
		else $error("side output does not follow side select pin");
	chk_meas_start: assert property (sideToggle |=> measState_reg == MEAS_RUN && measCount_reg == 10'h000) // [R3]
		else $error("side switch did not restart measurement");
	chk_meas_length: assert property (measDone |-> measCount_reg == measTarget - 10'h001) // [R3]
		else $error("measurement ended at wrong count");
	chk_ready_low: assert property (measDone |=> !resultReadyN && serialOutLanes[0] == $past(packedWords[CHAIN_BITS-1])) // [R4]
		else $error("result ready not shown after measurement");
	chk_ready_release: assert property (!resultReadyN && dclkFall && !loadNow |=> resultReadyN) // [R6]
		else $error("ready did not return high after first shift edge");
	chk_daisy_take: assert property (dclkRise |=> daisyBit_reg == $past(pinSync_reg[PIN_DAISY])) // [R8]
		else $error("daisy bit not sampled on shift rising edge");
	chk_cfg_capture: assert property (armed_reg && mclkFall |=> cfgShift_reg[0] == $past(pinSync_reg[PIN_CFG])) // [R9]
		else $error("config bit not captured on master falling edge");
	chk_readback_msb: assert property (readbackLoad |=> !resultReadyN && serialOutLanes[0] == $past(cfg_reg[CFG_BITS-1])) // [R10] [R11]
		else $error("readback did not present config msb");
	chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle wide");

	cov_meas_done: cover property (measDone);
	cov_readback: cover property (readbackLoad ##[1:1000] dclkFall);
	cov_overrun: cover property (irqEvents[IRQ_OVERRUN]);
	cov_cfg_done: cover property (cfgDone);
endmodule
`default_nettype wire

// ===== pkg/lane_if.sv
// load and shift signals between the core and one output lane
`timescale 1ns/100ps
`default_nettype none
interface lane_if #(parameter int BITS = 64);
	logic            loadEn;
	logic            shiftEn;
	logic [BITS-1:0] loadWord;
	logic            serialIn;
	logic            serialOut;
	modport ctrl (output loadEn, output shiftEn, output loadWord, output serialIn, input serialOut);
	modport lane (input loadEn, input shiftEn, input loadWord, input serialIn, output serialOut);
endinterface
`default_nettype wire

// ===== pkg/readout_pkg.sv
// constants and types shared by the integrator readout block
// Functional notes
// R1 - host keeps each integration 400..1000 clocks, or 800..40000 with short integration
// R2 - side select high integrates side A, low integrates side B
// R3 - measurement completes 274 master clocks after a side switch, 544 with short integration
// R4 - data-valid goes low when result data wait in the output shifter
// R5 - reset low holds all digital logic in reset; high runs normally
// R6 - data-valid returns high after the first shift clock falling edge of a readout
// R7 - every lane advances one bit on each shift clock falling edge
// R8 - daisy input is sampled on each shift clock rising edge and passed through
// R9 - configuration write bits are captured on master clock falling edges
// R10 - during readback data-valid changes on a master clock falling edge
// R11 - readback puts configuration bit 15 first on lane one, then bits per falling edge
// R12 - results are straight binary; word length follows the resolution setting
// R13 - reference bypass bit 0 selects internal buffer, 1 selects external buffer mode
// R14 - 12-bit resolution drops four low bits, 14-bit drops two low bits
// R15 - two-bit gain setting for all integrators: 00 3pC, 01 6pC, 10 12pC
// R16 - host toggles side select aligned to a master clock rising edge
// R17 - sixteen results shift out msb first, one after another, from data-valid; four-lane mode sends four results on each lane in parallel
// R18 - host reads only after data-valid low and finishes before the next result
`default_nettype none
package readout_pkg;
	localparam int CH_COUNT     = 16;
	localparam int WORD_BITS    = 16;
	localparam int LANE_COUNT   = 4;
	localparam int CH_PER_LANE  = CH_COUNT / LANE_COUNT;
	localparam int LANE_BITS    = CH_PER_LANE * WORD_BITS;
	localparam int CHAIN_BITS   = CH_COUNT * WORD_BITS;
	localparam int RES_WIDTH_14 = 14;
	localparam int RES_WIDTH_12 = 12;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG   = 8'h00;
	localparam logic [7:0] OFS_CTRL     = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// configuration word layout
	localparam int          CFG_BITS          = 16;
	localparam logic [3:0]  CFG_LAST_BIT      = 4'hF;
	localparam logic [15:0] CFG_RESET         = 16'h0000;
	localparam int          CFG_RANGE_LSB     = 0;
	localparam int          CFG_RES_LSB       = 2;
	localparam int          CFG_SHORT_BIT     = 4;
	localparam int          CFG_BYPASS_BIT    = 5;
	localparam int          CFG_FOUR_LANE_BIT = 6;
	localparam logic [1:0]  RES_16            = 2'h0;
	localparam logic [1:0]  RES_14            = 2'h1;
	localparam logic [1:0]  RES_12            = 2'h2;
	localparam logic [1:0]  RANGE_3PC         = 2'h0;
	localparam logic [1:0]  RANGE_6PC         = 2'h1;
	localparam logic [1:0]  RANGE_12PC        = 2'h2;
	// control, status and interrupt bits
	localparam int CTRL_ARM_BIT      = 0;
	localparam int CTRL_READBACK_BIT = 1;
	localparam int IRQ_BITS          = 4;
	localparam int IRQ_MEAS_DONE     = 0;
	localparam int IRQ_READ_START    = 1;
	localparam int IRQ_CFG_DONE      = 2;
	localparam int IRQ_OVERRUN       = 3;
	// measurement length in master clock periods
	localparam logic [9:0] MEAS_CLKS_NORMAL = 10'h112;
	localparam logic [9:0] MEAS_CLKS_SHORT  = 10'h220;
	// synchronised pin indices
	localparam int PIN_MCLK  = 0;
	localparam int PIN_SIDE  = 1;
	localparam int PIN_READOUT_SHIFT_CLOCK  = 2;
	localparam int PIN_DAISY = 3;
	localparam int PIN_CFG   = 4;
	localparam int PIN_COUNT = 5;
	typedef enum {MEAS_IDLE, MEAS_RUN} meas_state_t;
endpackage
`default_nettype wire

// ===== sim/host_model.sv
// host-side model: master clock, side select, shift clock, daisy and config pins
`timescale 1ns/100ps
`default_nettype none
module host_model (
	output logic            masterClk,
	output logic            integrateSideSelect,
	output logic            readoutShiftClock,
	output logic            daisyIn,
	output logic            cfgSerialIn,
	input  wire logic       resultReadyN,
	input  wire logic [3:0] serialOutLanes
);
	int         mcnt;
	int         lastSw;
	logic [4:0] cap [0:255];
	//****************************************
	// pin activity
	//****************************************
	// free-running master clock, edges never on a system clock edge
	initial begin
		masterClk = 1'b0;
		integrateSideSelect = 1'b0;
		readoutShiftClock = 1'b0;
		daisyIn = 1'b0;
		cfgSerialIn = 1'b0;
		mcnt = 0;
		lastSw = -1000;
		#3;
		forever begin
			#100 mcnt++;
			masterClk = 1'b1;
			#100 masterClk = 1'b0;
		end
	end
	// side switch on a rising edge once the minimum integration has run
	task automatic toggle_side(input int minClks);
		do @(posedge masterClk); while (mcnt - lastSw < minClks);
		integrateSideSelect <= ~integrateSideSelect;
		lastSw = mcnt;
	endtask
	// one frame; shift clock idles low outside it, samples taken just before each fall
	task automatic read_frame(input int n);
		#2 daisyIn = 1'b1; // off the system clock edge
		#40 readoutShiftClock = 1'b1;
		#40;
		for (int i = 0; i < n; i++) begin
			cap[i] = {resultReadyN, serialOutLanes};
			readoutShiftClock = 1'b0;
			#40 readoutShiftClock = 1'b1;
			#40;
		end
		readoutShiftClock = 1'b0;
		#80 daisyIn = 1'b0;
	endtask
	// config bit changes on a rising edge, stable at the next fall
	task automatic cfg_bit(input logic b);
		@(posedge masterClk);
		cfgSerialIn <= b;
	endtask
endmodule
`default_nettype wire

// ===== sim/multichannel_integrator_readout_tb.sv
// bench: drives the readout core over apb and the pin model, checks every output
`timescale 1ns/100ps
`default_nettype none
module multichannel_integrator_readout_tb
	import readout_pkg::*;
;
	logic                  clk_sys, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic                  masterClk, integrateSideSelect, readoutShiftClock, daisyIn, cfgSerialIn;
	logic                  resultReadyN, integratingSideA, refBufferBypass, shortIntegrationSelect;
	logic [1:0]            rangeSelect;
	logic [3:0]            serialOutLanes;
	logic [7:0]            paddr;
	logic [15:0]           w;
	logic [31:0]           pwdata, prdata, rd;
	logic [CHAIN_BITS-1:0] channelResults, data;
	realtime               lastFall;
	int                    error_cnt, compares, cyc;

	readout_core i_dut (
		.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterClk(masterClk),
		.integrateSideSelect(integrateSideSelect), .readoutShiftClock(readoutShiftClock), .daisyIn(daisyIn),
		.cfgSerialIn(cfgSerialIn), .channelResults(channelResults), .resultReadyN(resultReadyN),
		.serialOutLanes(serialOutLanes), .integratingSideA(integratingSideA), .rangeSelect(rangeSelect),
		.refBufferBypass(refBufferBypass), .shortIntegrationSelect(shortIntegrationSelect), .irq(irq)
	);
	host_model i_host (
		.masterClk(masterClk), .integrateSideSelect(integrateSideSelect), .readoutShiftClock(readoutShiftClock),
		.daisyIn(daisyIn), .cfgSerialIn(cfgSerialIn), .resultReadyN(resultReadyN), .serialOutLanes(serialOutLanes)
	);
	//****************************************
	// clock, hang guard and helpers
	//****************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(negedge masterClk) lastFall = $realtime;
	// cut a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end
	task automatic results();
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask
	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_ready();
		for (int n = 0; n < 20000 && resultReadyN !== 1'b0; n++) @(posedge clk_sys);
	endtask
	function automatic logic exp_bit(input int i, input int k, input int wb, input bit four);
		if (four) begin
			return (i < 64) ? data[255 - 64 * k - i] : (k == 3);
		end
		return data[255 - (i / wb) * 16 - i % wb];
	endfunction
	// fresh results, side switch, completion count
	task automatic measure(input int minC, input int expC);
		for (int k = 0; k < 8; k++) data[32 * k +: 32] = $urandom;
		@(posedge clk_sys);
		channelResults <= data;
		i_host.toggle_side(minC);
		repeat (8) @(posedge clk_sys);
		chk("sideA", i_host.integrateSideSelect, integratingSideA);
		wait_ready();
		chk("measClks", expC, i_host.mcnt - i_host.lastSw);
	endtask
	task automatic check_frame(input int nb, input int wb, input bit four);
		i_host.read_frame(nb);
		chk("readyLow", 0, i_host.cap[0][4]);
		chk("readyRise", 1, i_host.cap[1][4]);
		for (int i = 0; i < nb; i++) begin
			for (int k = 0; k < (four ? 4 : 1); k++) begin
				chk("laneBit", exp_bit(i, k, wb, four), i_host.cap[i][k]);
			end
		end
	endtask
	//****************************************
	// main sequence
	//****************************************
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		channelResults = '0;
		error_cnt = 0;
		compares = 0;
		cyc = 0;
		void'($urandom(32'hB565));
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		apb(0, OFS_CONFIG, 32'h0);
		chk("cfgReset", 32'h0, rd);
		apb(0, 8'h14, 32'h0);
		chk("unmapped", 1, err);
		for (int r = 0; r < 3; r++) begin
			w = 16'($urandom);
			w[1:0] = r[1:0];
			w[5] = r[0];
			apb(1, OFS_CONFIG, {16'h0, w});
			apb(0, OFS_CONFIG, 32'h0);
			chk("cfgRead", {16'h0, w}, rd);
			chk("range", w[1:0], rangeSelect);
			chk("bypass", w[5], refBufferBypass);
		end
		apb(1, OFS_CONFIG, 32'h0);
		measure(400, 274);
		apb(0, OFS_IRQ_STAT, 32'h0);
		chk("irqStat", 32'h1, rd);
		chk("irqMasked", 0, irq);
		apb(1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irqOn", 1, irq);
		apb(1, OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irqClear", 0, irq);
		check_frame(256, 16, 0);
		apb(1, OFS_CONFIG, 32'h8);
		measure(400, 274);
		check_frame(192, 12, 0);
		// configuration readback on lane one
		w = 16'($urandom);
		data[255 -: 16] = w;
		apb(1, OFS_CONFIG, {16'h0, w});
		apb(1, OFS_CTRL, 32'h2);
		wait_ready();
		chk("readyLag", 1, ($realtime - lastFall) < 80.0);
		check_frame(16, 16, 0);
		// serial configuration: short integration, four lanes, 16 bits
		w = 16'($urandom) & 16'hFFA3 | 16'h0050;
		i_host.cfg_bit(w[15]);
		apb(1, OFS_CTRL, 32'h1);
		for (int i = 14; i >= 0; i--) i_host.cfg_bit(w[i]);
		i_host.cfg_bit(~w[0]);
		apb(0, OFS_CONFIG, 32'h0);
		chk("serialCfg", {16'h0, w}, rd);
		chk("shortSel", 1, shortIntegrationSelect);
		measure(800, 544);
		check_frame(80, 16, 1);
		// fourteen-bit words on one lane
		apb(1, OFS_CONFIG, 32'h4);
		measure(400, 274);
		check_frame(224, 14, 0);
		// second reset in mid-run
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("rstReady", 1, resultReadyN);
		chk("rstOuts", 0, {rangeSelect, refBufferBypass, shortIntegrationSelect, irq, serialOutLanes});
		rstn <= 1'b1;
		apb(0, OFS_IRQ_STAT, 32'h0);
		chk("irqAfterRst", 32'h0, rd);
		results();
	end
endmodule
`default_nettype wire
